// [hdl/mib_counter_indirect_readout.sv]
// Statistics counter store with indirect read-clear access through byte registers.
`timescale 1ns/1ps
module mib_counter_indirect_readout (
  input wire logic clk,
  input wire logic rstn,
  input mib_pkg::port_events_s ev [mib_pkg::NPORT],
  input mib_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic rvalid
);
  logic [mib_pkg::CNT_W-1:0] cnt_q [mib_pkg::NSLOT];
  logic ovf_q [mib_pkg::NSLOT];
  logic [mib_pkg::NSLOT-1:0] clr;
  logic [7:0] sel_r, sel_nxt;
  logic [mib_pkg::RES_W-1:0] res_r, res_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic trig;
  logic slot_ok;
  logic [7:0] slot;
  logic [8:0] slot_w;

  // The index write alone starts the read; the table select only steers it.
  assign trig = req.wr && req.addr == mib_pkg::REG_IDX;

  // Decode select and index into a storage slot, flagging holes as invalid.
  always_comb begin
    slot_ok = 1'b0;
    slot_w = 9'h000;
    if (sel_r == mib_pkg::SEL_PORT) begin
      slot_w = {4'h0, req.wdata[4:0]};
      case (req.wdata[7:5])
        mib_pkg::PBASE_P1: begin
          slot_ok = 1'b1;
        end
        mib_pkg::PBASE_P2: begin
          slot_ok = 1'b1;
          slot_w = slot_w + 9'(mib_pkg::NOFF);
        end
        mib_pkg::PBASE_P3: begin
          slot_ok = 1'b1;
          slot_w = slot_w + 9'(2 * mib_pkg::NOFF);
        end
        mib_pkg::PBASE_P4: begin
          slot_ok = 1'b1;
          slot_w = slot_w + 9'(3 * mib_pkg::NOFF);
        end
        mib_pkg::PBASE_RSV: begin
          slot_ok = 1'b0;
        end
        default: begin
          slot_ok = 1'b0;
        end
      endcase
    end else if (sel_r == mib_pkg::SEL_TOTAL) begin
      slot_ok = req.wdata <= mib_pkg::TOTAL_LAST;
      slot_w = 9'(mib_pkg::NPKT) + {1'b0, req.wdata};
    end
    slot = slot_w[7:0];
  end

  // One counter per slot. A read clears the old value while this cycle's event
  // lands in the fresh count, so nothing is lost or counted twice.
  genvar g;
  generate
    for (g = 0; g < mib_pkg::NSLOT; g++) begin : g_slot
      localparam int KIND = (g - mib_pkg::NPKT) % 4;
      localparam int W = (g < mib_pkg::NPKT) ? mib_pkg::PKT_W :
        ((KIND < 2) ? mib_pkg::BYTE_W : mib_pkg::DROP_W);
      localparam int P = (g < mib_pkg::NPKT) ? g / mib_pkg::NOFF : (g - mib_pkg::NPKT) / 4;
      logic [mib_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
      logic ovf_r, ovf_nxt;
      logic [mib_pkg::CNT_W:0] add, sum;

      assign clr[g] = trig && slot_ok && slot == 8'(g);

      // Next count: add the event amount to the held or the just-cleared value.
      always_comb begin
        add = '0;
        if (g < mib_pkg::NPKT) begin
          add[0] = ev[P].pkt_inc[g % mib_pkg::NOFF];
        end else if (KIND == 0) begin
          add[mib_pkg::LEN_W-1:0] = ev[P].rx_byte_vld ? ev[P].rx_byte_len : '0;
        end else if (KIND == 1) begin
          add[mib_pkg::LEN_W-1:0] = ev[P].tx_byte_vld ? ev[P].tx_byte_len : '0;
        end else if (KIND == 2) begin
          add[0] = ev[P].rx_drop;
        end else begin
          add[0] = ev[P].tx_drop;
        end
        sum = (clr[g] ? '0 : {1'b0, cnt_r}) + add;
        cnt_nxt = '0;
        cnt_nxt[W-1:0] = sum[W-1:0];
        // Wrapping past the top sets the flag; only a read or reset drops it.
        ovf_nxt = (clr[g] ? 1'b0 : ovf_r) | sum[W];
      end

      // Counter registers.
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          cnt_r <= '0;
          ovf_r <= 1'b0;
        end else begin
          cnt_r <= cnt_nxt;
          ovf_r <= ovf_nxt;
        end
      end

      assign cnt_q[g] = cnt_r;
      assign ovf_q[g] = ovf_r;
    end
  endgenerate

  // Host registers: select store, result capture and registered byte readout.
  always_comb begin
    sel_nxt = sel_r;
    res_nxt = res_r;
    rdata_nxt = rdata_r;
    rvalid_nxt = req.rd;
    if (req.wr && req.addr == mib_pkg::REG_SEL) begin
      sel_nxt = req.wdata;
    end
    if (trig) begin
      res_nxt = mib_pkg::RES_RESET;
      if (slot_ok) begin
        res_nxt[mib_pkg::CNT_W-1:0] = cnt_q[slot];
        res_nxt[mib_pkg::OVF_BIT] = ovf_q[slot];
        res_nxt[mib_pkg::VLD_BIT] = 1'b1;
      end
    end
    if (req.rd) begin
      rdata_nxt = mib_pkg::BYTE_RESET;
      if (req.addr == mib_pkg::REG_SEL) begin
        rdata_nxt = sel_r;
      end else if (req.addr >= mib_pkg::REG_DATA_HI && req.addr <= mib_pkg::REG_DATA_LO) begin
        // Register 116 carries bits 39:32 and flags, 120 carries bits 7:0.
        rdata_nxt = 8'(res_r >> (8 * (mib_pkg::REG_DATA_LO - req.addr)));
      end
    end
  end

  // Host register state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sel_r <= mib_pkg::BYTE_RESET;
      res_r <= mib_pkg::RES_RESET;
      rdata_r <= mib_pkg::BYTE_RESET;
      rvalid_r <= 1'b0;
    end else begin
      sel_r <= sel_nxt;
      res_r <= res_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign rdata = rdata_r;
  assign rvalid = rvalid_r;
endmodule

// [hdl/mib_pkg.sv]
// Package with the constants and carriers of the statistics counter readout.
package mib_pkg;
  localparam int NPORT = 4;
  localparam int NOFF = 32;
  localparam int NPKT = NPORT * NOFF;
  localparam int NTOT = NPORT * 4;
  localparam int NSLOT = NPKT + NTOT;
  localparam int LEN_W = 11;
  localparam int PKT_W = 30;
  localparam int BYTE_W = 36;
  localparam int DROP_W = 16;
  localparam int CNT_W = 36;
  localparam int RES_W = 40;
  localparam int OVF_BIT = 38;
  localparam int VLD_BIT = 37;
  localparam logic [7:0] REG_SEL = 8'h6e;
  localparam logic [7:0] REG_IDX = 8'h6f;
  localparam logic [7:0] REG_DATA_HI = 8'h74;
  localparam logic [7:0] REG_DATA_LO = 8'h78;
  localparam logic [7:0] SEL_PORT = 8'h1c;
  localparam logic [7:0] SEL_TOTAL = 8'h1d;
  localparam logic [2:0] PBASE_P1 = 3'h0;
  localparam logic [2:0] PBASE_P2 = 3'h1;
  localparam logic [2:0] PBASE_P3 = 3'h2;
  localparam logic [2:0] PBASE_RSV = 3'h3;
  localparam logic [2:0] PBASE_P4 = 3'h4;
  localparam logic [7:0] TOTAL_LAST = 8'h0f;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam logic [RES_W-1:0] RES_RESET = 40'h00_0000_0000;

  // Counter events of one port from switch logic; each set bit or valid length is counted once per cycle it is held.
  typedef struct packed {
    logic [NOFF-1:0] pkt_inc;
    logic rx_byte_vld;
    logic [LEN_W-1:0] rx_byte_len;
    logic tx_byte_vld;
    logic [LEN_W-1:0] tx_byte_len;
    logic rx_drop;
    logic tx_drop;
  } port_events_s;

  // Host register access port.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;
endpackage

// [test/mib_readout_monitor.sv]
// Checker of the counter readout register port.
`timescale 1ns/1ps
module mib_readout_monitor (
  input wire logic clk,
  input wire logic rstn,
  input mib_pkg::port_events_s ev [mib_pkg::NPORT],
  input mib_pkg::reg_req_s req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_rd(a);
    req.rd && req.addr == a;
  endsequence
  sequence s_rsv_trig;
    req.wr && req.addr == 8'h6f && req.wdata[7:5] == 3'h3;
  endsequence
  a_read_answer: assert property (req.rd |=> rvalid) else $error("read not answered");
  a_no_stray: assert property (!req.rd |=> !rvalid) else $error("stray read valid");
  a_data_holds: assert property (!req.rd |=> $stable(rdata)) else $error("read data moved");
  a_unmapped_zero: assert property (req.rd && !(req.addr inside {8'h6e, [8'h74:8'h78]}) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_bit36_zero: assert property (s_rd(8'h74) |=> rdata[4] == 1'b0) else $error("bit 36 set");
  a_bit39_zero: assert property (s_rd(8'h74) |=> rdata[7] == 1'b0) else $error("bit 39 set");
  a_rsv_invalid: assert property (s_rsv_trig ##2 s_rd(8'h74) |=> rdata[5] == 1'b0)
    else $error("reserved index valid");
  a_sel_readback: assert property ((req.wr && req.addr == 8'h6e) ##2 (req.rd && !req.wr && req.addr == 8'h6e)
    |=> rdata == $past(req.wdata, 3)) else $error("select not read back");
endmodule

bind mib_counter_indirect_readout mib_readout_monitor mib_readout_monitor_inst (.clk(clk), .rstn(rstn),
  .ev(ev), .req(req), .rdata(rdata), .rvalid(rvalid));

// [test/tb_top.sv]
// Self-checking bench of the counter readout block.
`timescale 1ns/1ps
module tb_top;
  logic clk;
  logic rstn;
  mib_pkg::port_events_s ev [mib_pkg::NPORT];
  mib_pkg::reg_req_s req;
  logic [7:0] rdata;
  logic rvalid;
  int fails;
  int checked;
  mib_pkg::port_events_s e;

  mib_counter_indirect_readout mib_counter_indirect_readout_inst (.clk(clk), .rstn(rstn), .ev(ev), .req(req),
    .rdata(rdata), .rvalid(rvalid));

  // Free-running 50 MHz clock.
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    if (fails == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // One register access; a read is judged in its one-cycle answer, with d as the expected byte.
  task automatic acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    if (!wr) begin
      @(negedge clk);
      chk({7'h00, rvalid}, 8'h01);
      chk(rdata, d);
    end
  endtask

  // Pulses the pattern e on port p n times, with a gap between pulses.
  task automatic pulse(input int p, input int n);
    repeat (n) begin
      @(posedge clk);
      ev[p] <= e;
      @(posedge clk);
      ev[p] <= '0;
    end
  endtask

  task automatic s_pkt();
    e = '0;
    e.pkt_inc[13] = 1'b1;
    pulse(1, 3);
    acc(1, 8'h6e, 8'h1c);
    acc(1, 8'h6f, 8'h2d);
    acc(0, 8'h74, 8'h20);
    acc(0, 8'h75, 8'h00);
    acc(0, 8'h78, 8'h03);
    acc(1, 8'h6f, 8'h2d);
    acc(0, 8'h78, 8'h00);
    acc(1, 8'h6f, 8'h0d);
    acc(0, 8'h78, 8'h00);
  endtask

  // Two drops and two full-length frames add 2 and 0xffe.
  task automatic s_tot();
    e = '0;
    e.tx_drop = 1'b1;
    e.rx_byte_vld = 1'b1;
    e.rx_byte_len = 11'h7ff;
    pulse(0, 2);
    acc(1, 8'h6e, 8'h1d);
    acc(1, 8'h6f, 8'h03);
    acc(0, 8'h74, 8'h20);
    acc(0, 8'h77, 8'h00);
    acc(0, 8'h78, 8'h02);
    acc(1, 8'h6f, 8'h00);
    acc(0, 8'h77, 8'h0f);
    acc(0, 8'h78, 8'hfe);
  endtask

  // 65537 drops on port four wrap the 16-bit count once, leaving 1 and the sticky flag.
  task automatic s_ovf();
    @(posedge clk);
    ev[3].rx_drop <= 1'b1;
    repeat (65537) @(posedge clk);
    ev[3].rx_drop <= 1'b0;
    acc(1, 8'h6f, 8'h0e);
    acc(0, 8'h74, 8'h60);
    acc(0, 8'h78, 8'h01);
  endtask

  // The per-port table is selected first, so the reserved port base is what gets refused.
  task automatic s_bad();
    acc(1, 8'h6e, 8'h1c);
    acc(1, 8'h6f, 8'h60);
    acc(0, 8'h74, 8'h00);
    acc(0, 8'h64, 8'h00);
    acc(0, 8'h6e, 8'h1c);
  endtask

  // An event in the trigger cycle must land in the fresh count, not in the captured one.
  task automatic s_race();
    @(posedge clk);
    ev[0].pkt_inc[13] <= 1'b1;
    req <= '{wr: 1'b1, rd: 1'b0, addr: 8'h6f, wdata: 8'h0d};
    @(posedge clk);
    ev[0] <= '0;
    req <= '0;
    acc(0, 8'h78, 8'h00);
    acc(1, 8'h6f, 8'h0d);
    acc(0, 8'h78, 8'h01);
  endtask

  // Reset for two cycles, then the scenarios; select stays 0x1d from s_tot into s_ovf.
  initial begin
    rstn = 1'b0;
    req = '0;
    e = '0;
    fails = 0;
    checked = 0;
    for (int i = 0; i < mib_pkg::NPORT; i++) ev[i] = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    s_pkt();
    s_tot();
    s_ovf();
    s_bad();
    s_race();
    wrap_up();
  end
endmodule
